// *** bench/asp_checker.sv ***
// Concurrent checks on the two-wire bus between controller and target
`timescale 1ns/1ns
module asp_checker (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_oe_n,
  input wire logic dev_sda_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!reset_n_in);

  // Clock falls since the last START, saturating
  logic scl_q;
  logic [3:0] fall_q;
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      scl_q <= 1'b1;
      fall_q <= 4'hf;
    end else begin
      scl_q <= scl;
      if (scl && $fell(sda)) begin
        fall_q <= 4'h0;
      end else if (scl_q && !scl && fall_q != 4'hf) begin
        fall_q <= fall_q + 4'h1;
      end
    end
  end

  sequence s_start;
    scl && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $rose(sda);
  endsequence
  sequence s_addr_end;
    $fell(scl) && fall_q == 4'h8;
  endsequence

  a_dev_only_low: assert property (dev_sda_out == 1'b0 && (dev_sda_oe_n || !sda))
    else $error("target drives data line high");
  a_start_shape: assert property (s_start |-> ##[1:300] !scl)
    else $error("clock not lowered after start");
  a_stop_free: assert property (s_stop |-> (scl && sda) [*8])
    else $error("bus not free after stop");
  a_oe_steady_high: assert property ($changed(dev_sda_oe_n) |-> !scl)
    else $error("target changed data while clock high");
  a_quiet_addr: assert property (fall_q < 4'h9 |-> dev_sda_oe_n)
    else $error("target drove during address byte");
  a_host_ack_release: assert property (fall_q == 4'h9 && scl |-> host_sda_oe_n)
    else $error("controller held data in ack slot");
  a_addr_acked: assert property (fall_q == 4'h9 && scl |-> !sda)
    else $error("own address not acknowledged");
  a_ack_timely: assert property (s_addr_end |-> ##[1:8] !dev_sda_oe_n)
    else $error("acknowledge late");
endmodule

// *** bench/tb_top.sv ***
// Testbench joining controller and target over the two-wire bus
`timescale 1ns/1ns
module tb_top;
  import asp_pkg::*;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic en = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [7:0] cmd_len = 8'h00;
  logic wr_rdy = 1'b0;
  logic cmd_ready, rd_valid, done, nack, wr_valid, busy, busy_2;
  logic [7:0] rd_data, reg_addr, rdata, wr_addr, wr_data;
  int fails = 0;
  int samples_checked = 0;
  logic [7:0] rd_q[$];
  logic [8:0] wire_q[$];
  logic ps = 1'b1;
  logic pd = 1'b1;
  logic [8:0] sh = 9'h000;
  int nb = 0;

  always #5 clock_in = ~clock_in;
  assign rdata = reg_addr ^ 8'ha5;

  asp_bus_if u_asp_bus_if ();
  asp_bus_if u_asp_bus_if_2 ();
  asp_controller #(.SCL_HZ(ASP_SCL_FAST_HZ)) u_asp_controller (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .clk_en_in(en), .bus(u_asp_bus_if), .cmd_valid_in(cmd_valid),
    .cmd_ready_out(cmd_ready), .cmd_read_in(cmd_read), .cmd_reg_in(cmd_reg),
    .cmd_wdata_in(cmd_wdata), .cmd_len_in(cmd_len), .rd_valid_out(rd_valid),
    .rd_data_out(rd_data), .done_out(done), .nack_out(nack));
  asp_target #(.FIFO_DEPTH(2)) u_asp_target (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .clk_en_in(en), .bus(u_asp_bus_if), .reg_addr_out(reg_addr), .reg_rdata_in(rdata),
    .wr_valid_out(wr_valid), .wr_ready_in(wr_rdy), .wr_addr_out(wr_addr),
    .wr_data_out(wr_data), .busy_out(busy));
  asp_target #(.FIFO_DEPTH(2)) u_asp_target_2 (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .clk_en_in(en), .bus(u_asp_bus_if_2), .reg_addr_out(), .reg_rdata_in(8'h00),
    .wr_valid_out(), .wr_ready_in(1'b1), .wr_addr_out(), .wr_data_out(), .busy_out(busy_2));
  asp_checker u_asp_checker (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .scl(u_asp_bus_if.scl), .sda(u_asp_bus_if.sda), .host_sda_oe_n(u_asp_bus_if.host_sda_oe_n),
    .dev_sda_oe_n(u_asp_bus_if.dev_sda_oe_n), .dev_sda_out(u_asp_bus_if.dev_sda_out));

  // Wire monitor: nine bits per unit, restarted by START
  always @(posedge clock_in) begin
    ps <= u_asp_bus_if.scl;
    pd <= u_asp_bus_if.sda;
    if (ps && u_asp_bus_if.scl && pd && !u_asp_bus_if.sda) begin
      nb <= 0;
    end else if (!ps && u_asp_bus_if.scl) begin
      sh = {sh[7:0], u_asp_bus_if.sda};
      if (nb == 8) begin
        wire_q.push_back(sh);
        nb <= 0;
      end else begin
        nb <= nb + 1;
      end
    end
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic run_cmd(input logic rd, input logic [7:0] rg, wd, ln);
    int n;
    rd_q.delete();
    wire_q.delete();
    @(negedge clock_in);
    cmd_valid = 1'b1;
    cmd_read = rd;
    cmd_reg = rg;
    cmd_wdata = wd;
    cmd_len = ln;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clock_in);
      n++;
    end
    if (n >= 100) begin
      fails++;
      wrap_up();
    end
    @(negedge clock_in);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 40000) begin
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
      @(negedge clock_in);
      n++;
    end
    if (n >= 40000) begin
      fails++;
      wrap_up();
    end
    repeat (8) @(negedge clock_in);
  endtask

  task automatic chk_wire(input logic [7:0] eb[$], input int nak);
    check("wire count", 16'(wire_q.size()), 16'(eb.size()));
    foreach (eb[i]) begin
      check("wire unit", {7'h00, wire_q[i]}, {7'h00, eb[i], i == nak});
    end
  endtask

  // Second bus: the bench plays a controller bit by bit
  task automatic bb(input logic c, input logic d);
    u_asp_bus_if_2.host_scl_oe_n = c;
    u_asp_bus_if_2.host_sda_oe_n = d;
    repeat (4) @(negedge clock_in);
  endtask

  initial begin
    u_asp_bus_if_2.host_scl_out = 1'b0;
    u_asp_bus_if_2.host_sda_out = 1'b0;
    u_asp_bus_if_2.host_scl_oe_n = 1'b1;
    u_asp_bus_if_2.host_sda_oe_n = 1'b1;
    repeat (12) @(negedge clock_in);
    reset_n_in = 1'b1;
    check("pointer", {8'h00, reg_addr}, {8'h00, ASP_PTR_RESET});
    check("idle lines", {14'h0, u_asp_bus_if.scl, u_asp_bus_if.sda}, 16'h0003);
    check("busy", {15'h0, busy}, 16'h0000);
    // Two writes fill the FIFO, the third is refused
    run_cmd(1'b0, 8'h2a, 8'h5c, 8'h00);
    chk_wire('{ASP_ADDR_BYTE_WR, 8'h2a, 8'h5c}, -1);
    check("pointer", {8'h00, reg_addr}, 16'h002b);
    check("nack", {15'h0, nack}, 16'h0000);
    check("busy", {15'h0, busy}, 16'h0000);
    run_cmd(1'b0, 8'h31, 8'h81, 8'h00);
    run_cmd(1'b0, 8'h40, 8'h77, 8'h00);
    chk_wire('{ASP_ADDR_BYTE_WR, 8'h40, 8'h77}, 2);
    check("nack", {15'h0, nack}, 16'h0001);
    check("pointer", {8'h00, reg_addr}, 16'h0040);
    for (int i = 0; i < 2; i++) begin
      check("fifo valid", {15'h0, wr_valid}, 16'h0001);
      check("fifo word", {wr_addr, wr_data}, (i == 0) ? 16'h2a5c : 16'h3181);
      wr_rdy = 1'b1;
      @(negedge clock_in);
      wr_rdy = 1'b0;
    end
    check("fifo valid", {15'h0, wr_valid}, 16'h0000);
    // Burst read of three bytes
    run_cmd(1'b1, 8'h10, 8'h00, 8'h03);
    chk_wire('{ASP_ADDR_BYTE_WR, 8'h10, ASP_ADDR_BYTE_RD, 8'hb5, 8'hb4, 8'hb7}, 5);
    check("read count", 16'(rd_q.size()), 16'h0003);
    for (int i = 0; i < 3; i++) begin
      check("read byte", {8'h00, rd_q[i]}, {8'h00, (8'h10 + 8'(i)) ^ 8'ha5});
    end
    check("pointer", {8'h00, reg_addr}, 16'h0013);
    // Single read at the top register, pointer wraps
    run_cmd(1'b1, 8'hff, 8'h00, 8'h01);
    chk_wire('{ASP_ADDR_BYTE_WR, 8'hff, ASP_ADDR_BYTE_RD, 8'h5a}, 3);
    check("read byte", {8'h00, rd_q[0]}, 16'h005a);
    check("pointer", {8'h00, reg_addr}, 16'h0000);
    // Frozen clock enable: a command is not taken
    en = 1'b0;
    cmd_valid = 1'b1;
    repeat (4) @(negedge clock_in);
    check("frozen", {14'h0, cmd_ready, busy}, 16'h0002);
    cmd_valid = 1'b0;
    @(negedge clock_in);
    en = 1'b1;
    // Foreign address on the second bus
    bb(1'b1, 1'b0);
    bb(1'b0, 1'b0);
    for (int i = 7; i >= 0; i--) begin
      bb(1'b0, 1'(8'h40 >> i));
      bb(1'b1, 1'(8'h40 >> i));
      bb(1'b1, 1'(8'h40 >> i));
      bb(1'b0, 1'(8'h40 >> i));
    end
    bb(1'b0, 1'b1);
    bb(1'b1, 1'b1);
    check("foreign ack", {14'h0, u_asp_bus_if_2.dev_sda_oe_n, u_asp_bus_if_2.sda},
      16'h0003);
    check("busy foreign", {15'h0, busy_2}, 16'h0001);
    bb(1'b0, 1'b1);
    bb(1'b0, 1'b0);
    bb(1'b1, 1'b0);
    bb(1'b1, 1'b1);
    check("busy foreign", {15'h0, busy_2}, 16'h0000);
    wrap_up();
  end
endmodule

// *** design/asp_bus_if.sv ***
// Two-wire bus joining controller and target, with pull-up resolution
`timescale 1ns/1ns
interface asp_bus_if;
  logic host_scl_out;
  logic host_scl_oe_n;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // Pull-ups hold a line high unless an enabled driver pulls it
  assign scl = host_scl_oe_n ? 1'b1 : host_scl_out;
  assign sda = (host_sda_oe_n ? 1'b1 : host_sda_out) & (dev_sda_oe_n ? 1'b1 : dev_sda_out);

  modport host (output host_scl_out, output host_scl_oe_n, output host_sda_out,
                output host_sda_oe_n, input sda);
  modport dev (output dev_sda_out, output dev_sda_oe_n, input scl, input sda);
endinterface

// *** design/asp_controller.sv ***
// Controller end: generates the bus clock and runs register transfers
`timescale 1ns/1ns
module asp_controller
  import asp_pkg::*;
#(
  parameter int CLK_HZ = ASP_CLK_HZ,
  parameter int SCL_HZ = ASP_SCL_STD_HZ
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  asp_bus_if.host bus,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic cmd_read_in,
  input wire logic [7:0] cmd_reg_in,
  input wire logic [7:0] cmd_wdata_in,
  input wire logic [7:0] cmd_len_in,
  output logic rd_valid_out,
  output logic [7:0] rd_data_out,
  output logic done_out,
  output logic nack_out
);
  localparam int QTR_CYC = CLK_HZ / (4 * SCL_HZ);

  if (QTR_CYC < ASP_QTR_MIN_CYC || QTR_CYC > 65535) begin : g_chk
    $error("Bus clock rate not reachable from the system clock");
  end

  localparam logic [15:0] QTR_LAST = 16'(QTR_CYC - 1);

  typedef struct packed {
    logic [1:0] sda_s;
    asp_ctl_state_t st;
    asp_ctl_step_t step;
    logic [15:0] qcnt;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic rx;
    logic nak_out;
    logic acked;
    logic rd;
    logic [7:0] rreg;
    logic [7:0] wdata;
    logic [7:0] left;
    logic scl_oe_n;
    logic sda_oe_n;
    logic nack;
    logic rd_valid;
    logic [7:0] rd_data;
    logic done;
  } asp_ctl_reg_t;

  asp_ctl_reg_t q;
  asp_ctl_reg_t d;
  logic tick;

  assign tick = (q.qcnt == QTR_LAST);

  always_comb begin
    d = q;
    d.rd_valid = 1'b0;
    d.done = 1'b0;
    d.sda_s = {q.sda_s[0], bus.sda};
    d.qcnt = (tick || q.st == H_IDLE) ? 16'h0000 : 16'(q.qcnt + 16'h0001);
    if (tick) begin
      d.ph = 2'(q.ph + 2'h1);
    end
    case (q.st)
      H_IDLE: begin
        d.ph = 2'h0;
        if (cmd_valid_in) begin
          d.rd = cmd_read_in;
          d.rreg = cmd_reg_in;
          d.wdata = cmd_wdata_in;
          d.left = (cmd_len_in == 8'h00) ? 8'h01 : cmd_len_in;
          d.nack = 1'b0;
          d.step = P_ADDRW;
          d.sh = ASP_ADDR_BYTE_WR;
          d.st = H_START;
        end
      end
      H_START: begin
        if (tick) begin
          case (q.ph)
            2'h0: d.sda_oe_n = 1'b1;
            2'h1: d.scl_oe_n = 1'b1;
            2'h2: d.sda_oe_n = 1'b0;
            default: begin
              d.scl_oe_n = 1'b0;
              d.bitn = 4'h0;
              d.rx = 1'b0;
              d.st = H_BIT;
            end
          endcase
        end
      end
      H_BIT: begin
        if (tick) begin
          case (q.ph)
            2'h0: begin
              if (q.bitn == ASP_ACK_SLOT) begin
                d.sda_oe_n = q.rx ? q.nak_out : 1'b1;
              end else begin
                d.sda_oe_n = q.rx ? 1'b1 : q.sh[7];
              end
            end
            2'h1: d.scl_oe_n = 1'b1;
            2'h2: begin
              if (q.bitn == ASP_ACK_SLOT) begin
                d.acked = ~q.sda_s[1];
              end else begin
                d.sh = {q.sh[6:0], q.sda_s[1]};
              end
            end
            default: begin
              d.scl_oe_n = 1'b0;
              d.bitn = 4'(q.bitn + 4'h1);
              if (q.bitn == ASP_ACK_SLOT) begin
                d.bitn = 4'h0;
                case (q.step)
                  P_ADDRW: begin
                    d.step = P_REG;
                    d.sh = q.rreg;
                  end
                  P_REG: begin
                    if (q.rd) begin
                      d.step = P_ADDRR;
                      d.sh = ASP_ADDR_BYTE_RD;
                      d.st = H_START;
                    end else begin
                      d.step = P_WDATA;
                      d.sh = q.wdata;
                    end
                  end
                  P_ADDRR: begin
                    d.step = P_RDATA;
                    d.rx = 1'b1;
                    d.nak_out = (q.left == 8'h01);
                  end
                  P_RDATA: begin
                    d.rd_valid = 1'b1;
                    d.rd_data = q.sh;
                    d.left = 8'(q.left - 8'h01);
                    d.nak_out = (q.left == 8'h02);
                    if (q.left == 8'h01) begin
                      d.st = H_STOP;
                    end
                  end
                  default: d.st = H_STOP;
                endcase
                if (!q.acked && q.step != P_RDATA) begin
                  d.nack = 1'b1;
                  d.st = H_STOP;
                end
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          case (q.ph)
            2'h0: d.sda_oe_n = 1'b0;
            2'h1: d.scl_oe_n = 1'b1;
            2'h2: d.sda_oe_n = 1'b1;
            default: begin
              d.done = 1'b1;
              d.st = H_IDLE;
            end
          endcase
        end
      end
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '{sda_s: 2'h3, st: H_IDLE, step: P_ADDRW, qcnt: 16'h0000, ph: 2'h0,
             bitn: 4'h0, sh: 8'h00, rx: 1'b0, nak_out: 1'b1, acked: 1'b0, rd: 1'b0,
             rreg: 8'h00, wdata: 8'h00, left: 8'h00, scl_oe_n: 1'b1, sda_oe_n: 1'b1,
             nack: 1'b0, rd_valid: 1'b0, rd_data: 8'h00, done: 1'b0};
    end else if (clk_en_in) begin
      q <= d;
    end
  end

  assign cmd_ready_out = (q.st == H_IDLE);
  assign rd_valid_out = q.rd_valid;
  assign rd_data_out = q.rd_data;
  assign done_out = q.done;
  assign nack_out = q.nack;
  assign bus.host_scl_out = 1'b0;
  assign bus.host_scl_oe_n = q.scl_oe_n;
  assign bus.host_sda_out = 1'b0;
  assign bus.host_sda_oe_n = q.sda_oe_n;
endmodule

// *** design/asp_pkg.sv ***
// Shared constants and types of the accelerometer serial port
package asp_pkg;
  localparam logic [6:0] ASP_TARGET_ADDR = 7'h1d;
  localparam logic ASP_DIR_READ = 1'b1;
  localparam logic ASP_DIR_WRITE = 1'b0;
  localparam logic [7:0] ASP_ADDR_BYTE_RD = {ASP_TARGET_ADDR, ASP_DIR_READ};
  localparam logic [7:0] ASP_ADDR_BYTE_WR = {ASP_TARGET_ADDR, ASP_DIR_WRITE};
  localparam logic [2:0] ASP_LAST_BIT = 3'h7;
  localparam logic [3:0] ASP_ACK_SLOT = 4'h8;
  localparam logic [7:0] ASP_PTR_RESET = 8'h00;
  localparam int ASP_CLK_HZ = 100_000_000;
  localparam int ASP_SCL_STD_HZ = 100_000;
  localparam int ASP_SCL_FAST_HZ = 400_000;
  localparam int ASP_QTR_STD_CYC = ASP_CLK_HZ / (4 * ASP_SCL_STD_HZ);
  localparam int ASP_QTR_MIN_CYC = 4;
  localparam int ASP_FIFO_DEPTH = 32;
  localparam int ASP_FIFO_WIDTH = 16;

  typedef enum logic [3:0] {
    T_IDLE, T_ADDR, T_AACK, T_REG, T_REGACK, T_WDATA, T_WACK, T_RDATA, T_RACK
  } asp_tgt_state_t;

  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} asp_ctl_state_t;

  typedef enum logic [2:0] {P_ADDRW, P_REG, P_WDATA, P_ADDRR, P_RDATA} asp_ctl_step_t;
endpackage

// *** design/asp_target.sv ***
// Target end of the serial port with its write-data FIFO
// Summary of operation
// - START is data falling while clock high
// - Bus busy from START until STOP
// - First byte: seven address bits, direction
// - Compare address after every START, match only
// - Receiver pulls ninth-pulse acknowledge low
// - Repeated START accepted mid transfer
// - STOP is data rising while clock high
// - Own address is hex 1D
// - Direction one reads, zero writes
// - Works at 100 and 400 kHz
// - Read bytes leave MSB first
// - Write phase selects register, both acknowledged
// - Read after repeated START returns selected register
// - Controller ends single read with NAK, STOP
// - Pointer advances after each byte sent
// - Burst continues while controller acknowledges
// - Unaddressed target leaves bus alone
// - Data line only pulled low or released
// - Written byte acknowledged, stored, STOP ends; with FIFO full it is not acknowledged and target goes idle
// - Pointer advances after each written byte the FIFO accepts
`timescale 1ns/1ns
module asp_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("FIFO depth must be a power of two, at least two");
  end
  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } asp_fifo_state_t;

  asp_fifo_state_t q, d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic full, empty, push, pop;

  assign empty = (q.wptr == q.rptr);
  assign full = (q.wptr[AW] != q.rptr[AW]) && (q.wptr[AW-1:0] == q.rptr[AW-1:0]);
  assign push = in_valid_in & ~full;
  assign pop = out_ready_in & ~empty;
  assign in_ready_out = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out = mem[q.rptr[AW-1:0]];

  always_comb begin
    d = q;
    if (push) begin
      d.wptr = (AW+1)'(q.wptr + 1'b1);
    end
    if (pop) begin
      d.rptr = (AW+1)'(q.rptr + 1'b1);
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '0;
    end else if (clk_en_in) begin
      q <= d;
    end
  end

  always_ff @(posedge clock_in) begin
    if (clk_en_in && push) begin
      mem[q.wptr[AW-1:0]] <= in_data_in;
    end
  end
endmodule

module asp_target
  import asp_pkg::*;
#(
  parameter int FIFO_DEPTH = ASP_FIFO_DEPTH
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  asp_bus_if.dev bus,
  output logic [7:0] reg_addr_out,
  input wire logic [7:0] reg_rdata_in,
  output logic wr_valid_out,
  input wire logic wr_ready_in,
  output logic [7:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  output logic busy_out
);
  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    asp_tgt_state_t st;
    logic [2:0] bitc;
    logic got8;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic mack;
    logic sda_oe_n;
    logic busy;
    logic push;
    logic [ASP_FIFO_WIDTH-1:0] pdata;
  } asp_tgt_reg_t;

  asp_tgt_reg_t q, d;
  logic rise, fall, start, stop;
  logic fifo_ready;
  logic [ASP_FIFO_WIDTH-1:0] fifo_out;

  // Condition on data while clock stays high; reads synced stages only
  function automatic logic line_cond(input logic [2:0] scl, input logic [2:0] sda,
                                     input logic rising);
    line_cond = scl[1] & scl[2] & (rising ? (sda[1] & ~sda[2]) : (~sda[1] & sda[2]));
  endfunction

  assign rise = q.scl_s[1] & ~q.scl_s[2];
  assign fall = ~q.scl_s[1] & q.scl_s[2];
  assign start = line_cond(q.scl_s, q.sda_s, 1'b0);
  assign stop = line_cond(q.scl_s, q.sda_s, 1'b1);

  always_comb begin
    d = q;
    d.push = 1'b0;
    d.scl_s = {q.scl_s[1:0], bus.scl};
    d.sda_s = {q.sda_s[1:0], bus.sda};
    if (start) begin
      d.st = T_ADDR;
      d.bitc = 3'h0;
      d.got8 = 1'b0;
      d.sda_oe_n = 1'b1;
      d.busy = 1'b1;
    end else if (stop) begin
      d.st = T_IDLE;
      d.sda_oe_n = 1'b1;
      d.busy = 1'b0;
    end else begin
      if (rise) begin
        d.bitc = 3'(q.bitc + 3'h1);
        d.got8 = (q.bitc == ASP_LAST_BIT);
        d.sh = (q.st == T_RDATA) ? q.sh : {q.sh[6:0], q.sda_s[1]};
        if (q.st == T_RACK) begin
          d.mack = ~q.sda_s[1];
        end
      end
      if (fall) begin
        case (q.st)
          T_ADDR: begin
            if (q.got8) begin
              d.got8 = 1'b0;
              if (q.sh[7:1] == ASP_TARGET_ADDR) begin
                d.rw = q.sh[0];
                d.sda_oe_n = 1'b0;
                d.st = T_AACK;
              end else begin
                d.st = T_IDLE;
              end
            end
          end
          T_AACK: begin
            d.bitc = 3'h0;
            if (q.rw == ASP_DIR_READ) begin
              d.sh = reg_rdata_in;
              d.sda_oe_n = reg_rdata_in[7];
              d.st = T_RDATA;
            end else begin
              d.sda_oe_n = 1'b1;
              d.st = T_REG;
            end
          end
          T_REG: begin
            if (q.got8) begin
              d.got8 = 1'b0;
              d.ptr = q.sh;
              d.sda_oe_n = 1'b0;
              d.st = T_REGACK;
            end
          end
          T_REGACK: begin
            d.bitc = 3'h0;
            d.sda_oe_n = 1'b1;
            d.st = T_WDATA;
          end
          T_WDATA: begin
            if (q.got8) begin
              d.got8 = 1'b0;
              if (fifo_ready) begin
                d.push = 1'b1;
                d.pdata = {q.ptr, q.sh};
                d.ptr = 8'(q.ptr + 8'h01);
                d.sda_oe_n = 1'b0;
                d.st = T_WACK;
              end else begin
                d.st = T_IDLE;
              end
            end
          end
          T_WACK: begin
            d.bitc = 3'h0;
            d.sda_oe_n = 1'b1;
            d.st = T_WDATA;
          end
          T_RDATA: begin
            if (q.got8) begin
              d.got8 = 1'b0;
              d.sda_oe_n = 1'b1;
              d.ptr = 8'(q.ptr + 8'h01);
              d.st = T_RACK;
            end else begin
              d.sh = {q.sh[6:0], 1'b0};
              d.sda_oe_n = q.sh[6];
            end
          end
          T_RACK: begin
            d.bitc = 3'h0;
            if (q.mack) begin
              d.sh = reg_rdata_in;
              d.sda_oe_n = reg_rdata_in[7];
              d.st = T_RDATA;
            end else begin
              d.st = T_IDLE;
            end
          end
          default: begin
            d.st = T_IDLE;
            d.sda_oe_n = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q <= '{scl_s: 3'h7, sda_s: 3'h7, st: T_IDLE, bitc: 3'h0, got8: 1'b0, sh: 8'h00,
             ptr: ASP_PTR_RESET, rw: 1'b0, mack: 1'b0, sda_oe_n: 1'b1, busy: 1'b0,
             push: 1'b0, pdata: '0};
    end else if (clk_en_in) begin
      q <= d;
    end
  end

  asp_fifo #(.WIDTH(ASP_FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .in_valid_in(q.push),
    .in_ready_out(fifo_ready),
    .in_data_in(q.pdata),
    .out_valid_out(wr_valid_out),
    .out_ready_in(wr_ready_in),
    .out_data_out(fifo_out)
  );

  assign wr_addr_out = fifo_out[15:8];
  assign wr_data_out = fifo_out[7:0];
  assign reg_addr_out = q.ptr;
  assign busy_out = q.busy;
  assign bus.dev_sda_out = 1'b0;
  assign bus.dev_sda_oe_n = q.sda_oe_n;
endmodule
